//--- rtl/pcpr_readout.sv
`timescale 1ns/1ps
`include "pcpr_cfg.svh"

// Behaviour
// - reset/enable low in serial mode clears counters, floats data output
// - chip select high after reset keeps counter stopped and data floating
// - select low, enable high: each config clock advances, data is driven
// - chip select high stops both counters and enters standby
// - after all data out and cascade low, data output floats
// - power-up resets the address counter on its own
// - in programming mode chip select has no effect
// - paging enable high splits read space into four equal pages
// - paging inputs ignored while programming enable is low
// - small variant pages are 64K words each, up to 3FFFF
// - large variant pages are 128K words each, up to 7FFFF
// - paging off reads the whole array from zero
// - cascade output goes low when counter reaches its maximum
// - cascade holds low, then follows select until enable falls
// - ready pulled low during power-up reset, released after
// - config clock pin is an input in programming mode
// - data three-state in read-out, open-collector when programming
// - program device select acts as chip select when programming
// - serial mode with select high: standby, data floats
// - next memory sees low select and drives its own data
module pcpr_readout
  import pcpr_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    config_clock,
  output logic                         config_clock_out,
  output logic                         config_clock_oe,
  input  wire logic                    reset_oe,
  input  wire logic                    chip_select_n,
  input  wire logic                    page_enable,
  input  wire logic [1:0]              page_select,
  input  wire logic                    serial_program_enable_n,
  input  wire logic                    program_device_select,
  input  wire logic                    variant_8m,
  input  wire logic                    prog_write,
  input  wire logic [`PCPR_ADDR_W-1:0] prog_addr,
  input  wire logic [`PCPR_WORD_W-1:0] prog_word,
  input  wire logic                    data_in,
  output logic                         data_out,
  output logic                         data_oe,
  output logic                         cascade_out_n,
  output logic                         ready_out,
  output logic                         ready_oe,
  output logic                         standby
);

  localparam logic [`PCPR_PWR_W-1:0] PWR_LAST =
    `PCPR_PWR_W'(`PCPR_POWERUP_CYC - 1);

  // end of a stored word; the stream ships bit 0 first
  function automatic logic word_end(input logic [`PCPR_BIT_W-1:0] idx);
    word_end = (idx == `PCPR_BIT_LAST);
  endfunction : word_end

  // cascade level for a state; it only means something in read-out,
  // so programming mode always shows it released high
  function automatic logic casc_level(
    input pcpr_casc_t st,
    input logic       ser,
    input logic       cs_n
  );
    casc_level = 1'b1;
    if (ser) begin
      unique case (st)
        PCPR_CASC_HIGH:   casc_level = 1'b1;
        PCPR_CASC_HOLD:   casc_level = 1'b0;
        PCPR_CASC_FOLLOW: casc_level = cs_n;
      endcase
    end
  endfunction : casc_level

  // power-up sequencing and density strap
  logic [`PCPR_PWR_W-1:0]  pwr_cnt;
  logic                    powered;
  logic                    big;

  // read-out state
  logic [`PCPR_ADDR_W-1:0] addr;
  logic [`PCPR_BIT_W-1:0]  bit_idx;
  logic [`PCPR_BIT_W-1:0]  bit_q;
  logic                    done;
  logic [`PCPR_ADDR_W-1:0] cur_top;
  logic                    clk_q;
  pcpr_casc_t              casc_state;

  wire logic [`PCPR_ADDR_W-1:0] page_base;
  wire logic [`PCPR_ADDR_W-1:0] page_top;
  wire logic [`PCPR_WORD_W-1:0] rd_word;

  // mode decode; the pin is high for read-out, low for programming
  wire logic serial_mode;
  wire logic prog_mode;
  wire logic paging_on;
  wire logic cfg_rise;
  wire logic ctr_clear;
  wire logic ctr_run;
  wire logic ctr_step;
  wire logic at_last_bit;
  wire logic at_top;
  wire logic drive_data;
  wire logic prog_accept;
  wire logic sel_active;

  // paging and select only count in read-out mode
  assign serial_mode = serial_program_enable_n;
  assign prog_mode   = ~serial_program_enable_n;
  assign paging_on   = page_enable & serial_mode;
  assign sel_active  = ~chip_select_n & serial_mode;

  // config clock is sampled as a plain input, edge found by one flop
  assign cfg_rise = config_clock & ~clk_q;

  // counter clear: power-up span or reset/enable low in serial mode
  assign ctr_clear = ~powered | (serial_mode & ~reset_oe);

  // counter runs only when selected and enabled, stops after the top
  assign ctr_run  = serial_mode & powered & reset_oe
                  & sel_active & ~done;
  assign ctr_step = ctr_run & cfg_rise;

  // end of a stored word, and end of the stream at the caught top
  assign at_last_bit = word_end(bit_idx);
  assign at_top      = (addr == cur_top);

  // three-state data driver enable in read-out
  assign drive_data = ctr_run;

  // programming writes need the device picked by its own select pin
  assign prog_accept = prog_mode & program_device_select
                     & prog_write & powered;

  pcpr_page_map u_page_map (
    .paging_on   (paging_on),
    .page_select (page_select),
    .variant_8m  (big),
    .page_base   (page_base),
    .page_top    (page_top)
  );

  pcpr_store u_store (
    .clk     (clk),
    .wr_en   (prog_accept),
    .wr_addr (prog_addr),
    .wr_word (prog_word),
    .rd_addr (addr),
    .rd_word (rd_word)
  );

  // power-up reset span; ready stays pulled low until it ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_cnt <= '0;
      powered <= 1'b0;
    end else if (!powered) begin
      pwr_cnt <= pwr_cnt + `PCPR_PWR_W'(1);
      powered <= (pwr_cnt == PWR_LAST);
    end
  end

  // density strap caught while the power-up span runs, never at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      big <= 1'b0;
    end else if (!powered) begin
      big <= variant_8m;
    end
  end

  // edge detector history for the config clock input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= config_clock;
    end
  end

  // next values of the address/bit counters and the end flag
  logic [`PCPR_ADDR_W-1:0] next_addr;
  logic [`PCPR_BIT_W-1:0]  next_bit_idx;
  logic                    next_done;

  always_comb begin
    next_addr    = addr;
    next_bit_idx = bit_idx;
    next_done    = done;
    if (ctr_clear) begin
      // clear loads the page base so the first bit is ready at once
      next_addr    = page_base;
      next_bit_idx = '0;
      next_done    = 1'b0;
    end else if (ctr_step) begin
      if (!at_last_bit) begin
        next_bit_idx = bit_idx + `PCPR_BIT_W'(1);
      end else if (at_top) begin
        next_done = 1'b1;            // no wrap: stream ends at the top
      end else begin
        next_addr    = addr + `PCPR_ADDR_W'(1);
        next_bit_idx = '0;
      end
    end
  end

  // counters hold whenever neither clearing nor stepping, which gives standby hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr    <= `PCPR_ADDR_ZERO;
      bit_idx <= '0;
      done    <= 1'b0;
    end else begin
      addr    <= next_addr;
      bit_idx <= next_bit_idx;
      done    <= next_done;
    end
  end

  // page top caught at every clear, so a page input that moves
  // mid-stream cannot shift or skip the end of the stream
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_top <= `PCPR_TOP_4M;
    end else if (ctr_clear) begin
      cur_top <= page_top;
    end
  end

  // bit index delayed to line up with the registered array read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_q <= '0;
    end else begin
      bit_q <= bit_idx;
    end
  end

  // cascade sequencing once the last bit has been shifted out
  pcpr_casc_t next_casc_state;
  logic       next_cascade_out_n;

  always_comb begin
    next_casc_state    = casc_state;
    next_cascade_out_n = 1'b1;
    unique case (casc_state)
      PCPR_CASC_HIGH: begin
        if (done && serial_mode) begin
          next_casc_state = PCPR_CASC_HOLD;
        end
      end
      PCPR_CASC_HOLD: begin
        // a clear while holding skips the follow phase altogether
        if (serial_mode && !reset_oe) begin
          next_casc_state = PCPR_CASC_HIGH;
        end else if (!sel_active) begin
          next_casc_state = PCPR_CASC_FOLLOW;
        end
      end
      PCPR_CASC_FOLLOW: begin
        if (!reset_oe) begin
          next_casc_state = PCPR_CASC_HIGH;
        end
      end
    endcase
    // output from the state being entered, so it lands with the flop
    next_cascade_out_n = casc_level(next_casc_state, serial_mode,
                                    chip_select_n);
  end

  // programming mode leaves cascade high; a clear also ends the hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      casc_state    <= PCPR_CASC_HIGH;
      cascade_out_n <= 1'b1;
    end else begin
      casc_state    <= next_casc_state;
      cascade_out_n <= next_cascade_out_n;
    end
  end

  // data pin: three-state stream in read-out, open collector when programming
  logic next_data_out;
  logic next_data_oe;

  always_comb begin
    next_data_out = 1'b0;
    next_data_oe  = 1'b0;
    if (serial_mode) begin
      next_data_out = rd_word[bit_q];
      next_data_oe  = drive_data;
    end else begin
      // open collector: only ever pulls low, never drives high
      next_data_out = 1'b0;
      next_data_oe  = prog_accept;    // low pulse acknowledges a write
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 1'b0;
      data_oe  <= 1'b0;
    end else begin
      data_out <= next_data_out;
      data_oe  <= next_data_oe;
    end
  end

  // ready is open collector: it only ever pulls low, during power-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_out <= 1'b0;
      ready_oe  <= 1'b1;
    end else begin
      ready_out <= 1'b0;
      ready_oe  <= ~powered;
    end
  end

  // standby flags the low-power state; counters already hold then
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      standby <= 1'b0;
    end else begin
      standby <= serial_mode & chip_select_n;
    end
  end

  // config clock pin is never driven by this end, always an input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_clock_out <= 1'b0;
      config_clock_oe  <= 1'b0;
    end else begin
      config_clock_out <= 1'b0;
      config_clock_oe  <= 1'b0;
    end
  end

endmodule : pcpr_readout

//--- rtl/pcpr_cfg.svh
`ifndef PCPR_CFG_SVH
`define PCPR_CFG_SVH

// system clock period and the power-up reset span
`define PCPR_CLK_NS       40
`define PCPR_POWERUP_NS   10000
`define PCPR_POWERUP_CYC  \
  ((`PCPR_POWERUP_NS + `PCPR_CLK_NS - 1) / `PCPR_CLK_NS)
`define PCPR_PWR_W        9

// word address, bit-in-word index and word width of the array
`define PCPR_ADDR_W       19
`define PCPR_BIT_W        4
`define PCPR_WORD_W       16
`define PCPR_BIT_LAST     4'hF

// page sizes and device tops, in word addresses
`define PCPR_PAGE_4M      19'h10000
`define PCPR_PAGE_8M      19'h20000
`define PCPR_TOP_4M       19'h3FFFF
`define PCPR_TOP_8M       19'h7FFFF
`define PCPR_ADDR_ZERO    19'h00000

`endif

//--- rtl/pcpr_pkg.sv
package pcpr_pkg;

  // cascade output sequencing after the last bit has gone out
  typedef enum logic [1:0] {
    PCPR_CASC_HIGH,
    PCPR_CASC_HOLD,
    PCPR_CASC_FOLLOW
  } pcpr_casc_t;

endpackage : pcpr_pkg

//--- rtl/pcpr_page_map.sv
`timescale 1ns/1ps
`include "pcpr_cfg.svh"

module pcpr_page_map
  import pcpr_pkg::*;
(
  input  wire logic                    paging_on,
  input  wire logic [1:0]              page_select,
  input  wire logic                    variant_8m,
  output logic      [`PCPR_ADDR_W-1:0] page_base,
  output logic      [`PCPR_ADDR_W-1:0] page_top
);

  // size of one page for the fitted density
  function automatic logic [`PCPR_ADDR_W-1:0] page_size(input logic big);
    page_size = big ? `PCPR_PAGE_8M : `PCPR_PAGE_4M;
  endfunction : page_size

  // first word of page n: n times the page size, n is 0..3
  function automatic logic [`PCPR_ADDR_W-1:0] page_start(
    input logic       big,
    input logic [1:0] n
  );
    logic [`PCPR_ADDR_W-1:0] sz;
    sz = page_size(big);
    page_start = (n[0] ? sz : `PCPR_ADDR_ZERO)
               + (n[1] ? {sz[`PCPR_ADDR_W-2:0], 1'b0} : `PCPR_ADDR_ZERO);
  endfunction : page_start

  wire logic [`PCPR_ADDR_W-1:0] dev_top;
  wire logic [`PCPR_ADDR_W-1:0] sel_base;

  // four equal pages when paging is on, whole array otherwise
  assign dev_top   = variant_8m ? `PCPR_TOP_8M : `PCPR_TOP_4M;
  assign sel_base  = page_start(variant_8m, page_select);
  assign page_base = paging_on ? sel_base : `PCPR_ADDR_ZERO;
  assign page_top  = paging_on
                   ? sel_base + page_size(variant_8m) - 19'h00001
                   : dev_top;

endmodule : pcpr_page_map

//--- rtl/pcpr_store.sv
`timescale 1ns/1ps
`include "pcpr_cfg.svh"

module pcpr_store
  import pcpr_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    wr_en,
  input  wire logic [`PCPR_ADDR_W-1:0] wr_addr,
  input  wire logic [`PCPR_WORD_W-1:0] wr_word,
  input  wire logic [`PCPR_ADDR_W-1:0] rd_addr,
  output logic      [`PCPR_WORD_W-1:0] rd_word
);

  // array sized for the larger density; the smaller one uses the low half
  logic [`PCPR_WORD_W-1:0] mem [0:(2**`PCPR_ADDR_W)-1];

  // no reset: contents are non-volatile, the read is one cycle late
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_word;
    end
    rd_word <= mem[rd_addr];
  end

endmodule : pcpr_store

//--- verification/pcpr_readout_properties.sv
`timescale 1ns/1ps

module pcpr_readout_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_oe,
  input wire logic chip_select_n,
  input wire logic serial_program_enable_n,
  input wire logic program_device_select,
  input wire logic prog_write,
  input wire logic data_out,
  input wire logic data_oe,
  input wire logic cascade_out_n,
  input wire logic ready_oe,
  input wire logic standby,
  input wire logic config_clock_oe
);
  logic [8:0] up_cnt;
  wire        ser = serial_program_enable_n;

  // edges since reset release, saturating so it never wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_cnt <= 9'h000;
    else if (up_cnt != 9'h1FF) up_cnt <= up_cnt + 9'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ready_span: assert property (up_cnt <= 9'h0FA |-> ready_oe)
    else $error("ready released early");
  a_ready_drop: assert property (up_cnt >= 9'h0FC |-> !ready_oe)
    else $error("ready still held low");
  a_standby_entry: assert property (
    ser && chip_select_n && !ready_oe |=> standby)
    else $error("no standby with select high");
  a_standby_float: assert property (standby |-> !data_oe)
    else $error("data driven in standby");
  a_clear_float: assert property (ser && !reset_oe |=> !data_oe)
    else $error("data driven while cleared");
  a_select_float: assert property (ser && chip_select_n |=> !data_oe)
    else $error("data driven while deselected");
  a_prog_ack: assert property (
    !ser && prog_write && program_device_select && !ready_oe
    |=> data_oe && !data_out)
    else $error("write not acknowledged");
  a_prog_quiet: assert property (
    !ser && !(prog_write && program_device_select) |=> !data_oe)
    else $error("data driven without write");
  a_casc_hold: assert property (
    !cascade_out_n && !chip_select_n && reset_oe && ser |=> !cascade_out_n)
    else $error("cascade released too soon");
  a_casc_float: assert property (ser && !cascade_out_n |-> !data_oe)
    else $error("data driven after cascade");
  a_clock_input: assert property (!config_clock_oe)
    else $error("config clock driven");

  cover property ($fell(ready_oe));
  cover property (!ser && data_oe);
  cover property (ser && standby);
  cover property (ser && data_oe);
endmodule : pcpr_readout_properties

bind pcpr_readout pcpr_readout_properties u_props (
  .clk(clk), .rst_n(rst_n), .reset_oe(reset_oe),
  .chip_select_n(chip_select_n),
  .serial_program_enable_n(serial_program_enable_n),
  .program_device_select(program_device_select),
  .prog_write(prog_write), .data_out(data_out), .data_oe(data_oe),
  .cascade_out_n(cascade_out_n), .ready_oe(ready_oe),
  .standby(standby), .config_clock_oe(config_clock_oe)
);

//--- verification/pcpr_fpga_model.sv
`timescale 1ns/1ps

module pcpr_fpga_model (
  input  wire logic clk,
  input  wire logic data_pin,
  output logic      config_clock
);
  // clock rests low between frames
  initial config_clock = 1'b0;

  // take the bit on show, then one clock period; slack widens the
  // high phase so a slow master is exercised too
  task automatic step(output logic b, input int slack);
    b = data_pin;
    config_clock = 1'b1;
    repeat (4 + slack) @(negedge clk);
    config_clock = 1'b0;
    repeat (4) @(negedge clk);
  endtask : step
endmodule : pcpr_fpga_model

//--- verification/pcpr_readout_tb.sv
`timescale 1ns/1ps
`include "pcpr_cfg.svh"

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  n_errors++; $display("BAD %0t got %0h want %0h", $time, got, exp); end end

module pcpr_readout_tb
  import pcpr_pkg::*;
;
  logic                    clk, rst_n, reset_oe, chip_select_n, b;
  logic                    page_enable, serial_program_enable_n;
  logic                    program_device_select, variant_8m, prog_write;
  logic [1:0]              page_select;
  logic [`PCPR_ADDR_W-1:0] prog_addr;
  logic [`PCPR_WORD_W-1:0] prog_word;
  wire                     config_clock, data_out, data_oe, data_pin;
  wire                     cascade_out_n, ready_oe, standby;
  wire                     config_clock_out, config_clock_oe, ready_out;
  wire                     next_chip_select_n;
  int                      n_errors, checks, n, p;
  logic [15:0]             mem [int];

  always #20 clk = ~clk;
  // released data line floats up to the pull-up
  assign data_pin = data_oe ? data_out : 1'b1;
  // the next memory in the chain takes its select from the cascade
  assign next_chip_select_n = cascade_out_n;

  pcpr_readout dut (
    .clk, .rst_n, .config_clock, .config_clock_out, .config_clock_oe,
    .reset_oe, .chip_select_n, .page_enable, .page_select,
    .serial_program_enable_n, .program_device_select, .variant_8m,
    .prog_write, .prog_addr, .prog_word, .data_in(data_pin), .data_out,
    .data_oe, .cascade_out_n, .ready_out, .ready_oe, .standby
  );

  pcpr_fpga_model u_fpga (.clk, .data_pin, .config_clock);

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // one programming write; ack expected only when selected
  task automatic wr(input int a, input logic [15:0] w, input logic sel);
    prog_addr = a[18:0];
    prog_word = w;
    program_device_select = sel;
    prog_write = 1'b1;
    @(negedge clk);
    `CHK({data_oe, data_out}, {sel, 1'b0})
    if (sel) mem[a] = w;
  endtask : wr

  // bits come out word by word, bit 0 first
  task automatic read_run(input int base, input int nb, input int from);
    for (int k = from; k < from + nb; k++) begin
      u_fpga.step(b, $urandom % 3);
      `CHK(b, mem[base + k / 16][k % 16])
    end
  endtask : read_run

  initial begin
    clk = 0; rst_n = 0; reset_oe = 0; chip_select_n = 1; page_enable = 0;
    page_select = 0; serial_program_enable_n = 1; variant_8m = 0;
    program_device_select = 0; prog_write = 0; prog_addr = 0; prog_word = 0;
    n_errors = 0; checks = 0;
    void'($urandom(32'hB8EDC2BB));
    repeat (20) @(negedge clk);
    `CHK({ready_oe, data_oe, next_chip_select_n}, 3'b101)
    rst_n = 1;
    n = 0;
    while (ready_oe !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    `CHK(n, `PCPR_POWERUP_CYC + 1)
    `CHK({config_clock_oe, config_clock_out, ready_out}, 3'b000)
    if (n >= 400) conclude();
    // programming with select high, then one write with select low, and page select set to a random value
    serial_program_enable_n = 0;
    page_select = 2'($urandom);
    p = $urandom % 4;
    for (int i = 0; i < 3; i++) begin
      wr(p * 65536 + i, 16'($urandom), 1'b1);
      wr(i, 16'($urandom), 1'b1);
    end
    wr(p * 65536 + 3, 16'($urandom), 1'b0);
    prog_write = 0;
    serial_program_enable_n = 1;
    // paged read of page p, then unpaged read from zero
    for (int pe = 1; pe >= 0; pe--) begin
      page_enable = pe[0];
      page_select = p[1:0];
      chip_select_n = 0;
      reset_oe = 0;
      repeat (3) @(negedge clk);
      `CHK(data_oe, 1'b0)
      reset_oe = 1;
      repeat (2) @(negedge clk);
      `CHK(data_oe, 1'b1)
      read_run(pe * p * 65536, 20, 0);
      chip_select_n = 1;
      repeat (2) @(negedge clk);
      `CHK({standby, data_oe, next_chip_select_n}, 3'b101)
      u_fpga.step(b, 0);
      u_fpga.step(b, 0);
      chip_select_n = 0;
      repeat (2) @(negedge clk);
      read_run(pe * p * 65536, 28, 20);
    end
    // clear mid-stream restarts at the first bit
    reset_oe = 0;
    repeat (2) @(negedge clk);
    reset_oe = 1;
    repeat (2) @(negedge clk);
    read_run(0, 4, 0);
    conclude();
  end
endmodule : pcpr_readout_tb
